// ==== src/shunt_pkg.sv ====
// Shared constants for the shunt power engine and its two-wire host.
package shunt_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLOCK_KHZ = 125000;
	localparam int TIMEOUT_MS = 28;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLOCK_KHZ;
	localparam int LINK_RATE_KHZ = 100;
	localparam int QUARTER_CYCLES = CLOCK_KHZ / (LINK_RATE_KHZ * 4);

	// ----------------------------------------
	// Device register pointers and values
	// ----------------------------------------
	localparam logic [7:0] PTR_CONFIG = 8'h00;
	localparam logic [7:0] PTR_SHUNT = 8'h01;
	localparam logic [7:0] PTR_BUS = 8'h02;
	localparam logic [7:0] PTR_POWER = 8'h03;
	localparam logic [7:0] PTR_CURRENT = 8'h04;
	localparam logic [7:0] PTR_CAL = 8'h05;
	// 32 V range, gain /8 (320 mV), 12-bit shunt and bus, continuous both.
	localparam logic [15:0] CONFIG_RESET = 16'h399f;
	localparam logic [15:0] CAL_RESET = 16'h0000;
	localparam int BUS_VOLTAGE_BIT0_POS = 3;
	localparam int CURRENT_DIVISOR = 4096;
	localparam int POWER_DIVISOR = 5000;
	localparam logic [4:0] ADDR_BASE = 5'h10;

	// ----------------------------------------
	// Host register map (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] HOST_COMMAND = 5'h00;
	localparam logic [4:0] HOST_WDATA = 5'h04;
	localparam logic [4:0] HOST_STATUS = 5'h08;
	localparam logic [4:0] HOST_RDATA = 5'h0c;
	localparam logic [4:0] HOST_SLAVE = 5'h10;
	localparam int CMD_READ_BIT = 8;
	localparam int CMD_PTR_ONLY_BIT = 9;
	localparam logic [6:0] SLAVE_RESET = 7'h40;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : shunt_pkg

// ==== src/two_wire_if.sv ====
// Open-drain two-wire link joining the host end and the device end.
`timescale 1ns/1ps
interface two_wire_if;
	logic host_scl_out;
	logic host_scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;

	// A released line is pulled high; any enabled driver pulls it to its output.
	assign scl = host_scl_oe_n | host_scl_out;
	assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

	modport host (output host_scl_out, output host_scl_oe_n, output host_sda_out, output host_sda_oe_n,
		input scl, input sda);
	modport device (output dev_sda_out, output dev_sda_oe_n, input scl, input sda);
endinterface : two_wire_if

// ==== src/shunt_power_engine.sv ====
// Device end: two-wire slave, register file and current and power arithmetic.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - current is shunt times calibration over 4096
// - power is current times bus over 5000
// - bus reading stored shifted up three bits
// - shunt register count is ten microvolts
// - results only computed with calibration programmed
// - reset config is 12-bit, 320 mV, 32 V
// - every register returns to default at power-up
// - host derives calibration from current step, shunt
// - power step is twenty current steps
// - host alone drives clock, start and stop
// - start is data falling while clock high
// - address sampled on rising edges, eighth bit direction
// - matching address acknowledged on ninth pulse
// - each byte eight bits plus receiver acknowledge
// - data change with clock high is start/stop
// - stop is data rising while clock high
// - stalled transaction abandoned after 28 ms
// - first written byte loads the register pointer
// - reads return pointed register, high byte first
// - address pins sampled at each start
module shunt_power_engine #(
	parameter int TIMEOUT_CYCLES = shunt_pkg::TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	two_wire_if.device link,
	input wire logic [15:0] shunt_raw,
	input wire logic [12:0] bus_raw,
	input wire logic sample_valid,
	input wire logic [1:0] addr_sel,
	output var logic [15:0] config_word,
	output var logic [15:0] current_result,
	output var logic [15:0] power_result
);
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ADDR_ACK, D_WR, D_WR_ACK, D_RD, D_RD_ACK, D_IGNORE} dev_state_t;

	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	dev_state_t state;
	logic scl_q;
	logic sda_q;
	logic [3:0] cnt;
	logic [7:0] shift;
	logic rw;
	logic [1:0] sel_q;
	logic [1:0] byte_idx;
	logic [7:0] pointer;
	logic [7:0] msb_hold;
	logic wr_strobe;
	logic [15:0] wr_word;
	logic [15:0] tx_word;
	logic rd_hi;
	logic [15:0] cal;
	logic [15:0] shunt_reg;
	logic [15:0] bus_reg;
	logic calc_go;
	logic power_go;
	logic [TW-1:0] idle_cnt;
	logic timed_out;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] cur_byte;
	logic [15:0] read_now;
	logic signed [32:0] cur_quot;
	logic signed [29:0] pow_quot;

	function automatic logic [15:0] reg_read(input logic [7:0] ptr, input logic [15:0] cfg, input logic [15:0] sh,
		input logic [15:0] bv, input logic [15:0] pw, input logic [15:0] cu, input logic [15:0] cb);
		unique case (ptr)
			shunt_pkg::PTR_CONFIG: reg_read = cfg;
			shunt_pkg::PTR_SHUNT: reg_read = sh;
			shunt_pkg::PTR_BUS: reg_read = bv;
			shunt_pkg::PTR_POWER: reg_read = pw;
			shunt_pkg::PTR_CURRENT: reg_read = cu;
			shunt_pkg::PTR_CAL: reg_read = cb;
			default: reg_read = 16'h0000;
		endcase
	endfunction : reg_read

	// ----------------------------------------
	// Line events
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= link.scl;
			sda_q <= link.sda;
		end
	end

	assign scl_rise = link.scl & ~scl_q;
	assign scl_fall = ~link.scl & scl_q;
	assign start_seen = scl_q & link.scl & sda_q & ~link.sda;
	assign stop_seen = scl_q & link.scl & ~sda_q & link.sda;
	assign cur_byte = rd_hi ? tx_word[15:8] : tx_word[7:0];
	assign read_now = reg_read(pointer, config_word, shunt_reg, bus_reg, power_result, current_result, cal);
	assign link.dev_sda_out = 1'b0;

	// ----------------------------------------
	// Bus timeout
	// ----------------------------------------
	// stall timeout count
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_cnt <= '0;
			timed_out <= 1'b0;
		end
		else
		begin
			timed_out <= 1'b0;
			if (state == D_IDLE || scl_rise || scl_fall)
				idle_cnt <= '0;
			else if (idle_cnt == TW'(TIMEOUT_CYCLES - 1))
			begin
				idle_cnt <= '0;
				timed_out <= 1'b1;
			end
			else
				idle_cnt <= idle_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// Slave protocol
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= D_IDLE;
			cnt <= 4'h0;
			shift <= 8'h00;
			rw <= 1'b0;
			sel_q <= 2'h0;
			byte_idx <= 2'h0;
			pointer <= 8'h00;
			msb_hold <= 8'h00;
			wr_strobe <= 1'b0;
			wr_word <= 16'h0000;
			tx_word <= 16'h0000;
			rd_hi <= 1'b1;
			link.dev_sda_oe_n <= 1'b1;
		end
		else
		begin
			wr_strobe <= 1'b0;
			// line changes under high clock win
			if (start_seen)
			begin
				state <= D_ADDR;
				cnt <= 4'h0;
				byte_idx <= 2'h0;
				sel_q <= addr_sel;
				link.dev_sda_oe_n <= 1'b1;
			end
			else if (stop_seen || timed_out)
			begin
				state <= D_IDLE;
				link.dev_sda_oe_n <= 1'b1;
			end
			else if (scl_rise)
			begin
				if (state == D_ADDR || state == D_WR || state == D_RD)
				begin
					shift <= {shift[6:0], link.sda};
					cnt <= cnt + 1'b1;
				end
				if (state == D_RD_ACK && link.sda)
					state <= D_IGNORE;
			end
			else if (scl_fall)
			begin
				unique case (state)
					D_ADDR:
						if (cnt == 4'h8)
						begin
							rw <= shift[0];
							if (shift[7:1] == {shunt_pkg::ADDR_BASE, sel_q})
							begin
								state <= D_ADDR_ACK;
								link.dev_sda_oe_n <= 1'b0;
							end
							else
								state <= D_IGNORE;
						end
					D_ADDR_ACK:
					begin
						cnt <= 4'h0;
						if (rw)
						begin
							state <= D_RD;
							tx_word <= read_now;
							rd_hi <= 1'b1;
							link.dev_sda_oe_n <= read_now[15];
						end
						else
						begin
							state <= D_WR;
							link.dev_sda_oe_n <= 1'b1;
						end
					end
					D_WR:
						if (cnt == 4'h8)
						begin
							state <= D_WR_ACK;
							link.dev_sda_oe_n <= 1'b0;
							unique case (byte_idx)
								2'h0: pointer <= shift;
								2'h1: msb_hold <= shift;
								2'h2:
								begin
									wr_strobe <= 1'b1;
									wr_word <= {msb_hold, shift};
								end
								default: ;
							endcase
							if (byte_idx != 2'h3)
								byte_idx <= byte_idx + 1'b1;
						end
					D_WR_ACK:
					begin
						state <= D_WR;
						cnt <= 4'h0;
						link.dev_sda_oe_n <= 1'b1;
					end
					D_RD:
						if (cnt == 4'h8)
						begin
							state <= D_RD_ACK;
							link.dev_sda_oe_n <= 1'b1;
						end
						else
							link.dev_sda_oe_n <= cur_byte[~cnt[2:0]];
					D_RD_ACK:
					begin
						state <= D_RD;
						cnt <= 4'h0;
						rd_hi <= ~rd_hi;
						link.dev_sda_oe_n <= rd_hi ? tx_word[7] : tx_word[15];
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// defaults at every reset
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			config_word <= shunt_pkg::CONFIG_RESET;
			cal <= shunt_pkg::CAL_RESET;
		end
		else if (wr_strobe)
		begin
			if (pointer == shunt_pkg::PTR_CONFIG)
				config_word <= wr_word;
			if (pointer == shunt_pkg::PTR_CAL)
				cal <= wr_word;
		end
	end

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	// full precision, truncating division
	assign cur_quot = ($signed(shunt_reg) * $signed({1'b0, cal})) / 33'(shunt_pkg::CURRENT_DIVISOR);
	assign pow_quot = ($signed(current_result) * $signed({1'b0, bus_reg[15:shunt_pkg::BUS_VOLTAGE_BIT0_POS]}))
		/ 30'(shunt_pkg::POWER_DIVISOR);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shunt_reg <= 16'h0000;
			bus_reg <= 16'h0000;
			calc_go <= 1'b0;
			power_go <= 1'b0;
			current_result <= 16'h0000;
			power_result <= 16'h0000;
		end
		else
		begin
			calc_go <= sample_valid;
			power_go <= calc_go && cal != 16'h0000;
			if (sample_valid)
			begin
				shunt_reg <= shunt_raw;
				bus_reg <= {bus_raw, 3'b000};
			end
			if (calc_go && cal != 16'h0000)
				current_result <= cur_quot[15:0];
			if (power_go)
				power_result <= pow_quot[15:0];
		end
	end

endmodule : shunt_power_engine

// ==== src/two_wire_host.sv ====
// Host end: AXI4-Lite command registers driving a two-wire bus master.
`timescale 1ns/1ps
module two_wire_host #(
	parameter int QUARTER_CYCLES = shunt_pkg::QUARTER_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	two_wire_if.host link,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output var logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output var logic s_axi_wready,
	output var logic [1:0] s_axi_bresp,
	output var logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output var logic s_axi_arready,
	output var logic [31:0] s_axi_rdata,
	output var logic [1:0] s_axi_rresp,
	output var logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

	localparam int QW = $clog2(QUARTER_CYCLES + 1);

	host_state_t state;
	logic [4:0] aw_q;
	logic aw_have;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic w_have;
	logic go;
	logic [7:0] cmd_ptr;
	logic rd_mode;
	logic [1:0] last_byte;
	logic [15:0] wdata;
	logic [6:0] slave;
	logic [15:0] rx_word;
	logic nack;
	logic done;
	logic [QW-1:0] qcnt;
	logic [1:0] phase;
	logic [3:0] bit_idx;
	logic [1:0] byte_idx;
	logic [7:0] tx_byte;
	logic rx_byte;
	logic tick;

	assign link.host_scl_out = 1'b0;
	assign link.host_sda_out = 1'b0;
	assign tick = qcnt == QW'(QUARTER_CYCLES - 1);
	assign rx_byte = rd_mode && byte_idx != 2'h0;

	always_comb
	begin
		unique case (byte_idx)
			2'h0: tx_byte = {slave, rd_mode};
			2'h1: tx_byte = cmd_ptr;
			2'h2: tx_byte = wdata[15:8];
			default: tx_byte = wdata[7:0];
		endcase
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_q <= 5'h00;
			aw_have <= 1'b0;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			w_have <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= shunt_pkg::RESP_OKAY;
			go <= 1'b0;
			cmd_ptr <= 8'h00;
			rd_mode <= 1'b0;
			last_byte <= 2'h0;
			wdata <= 16'h0000;
			slave <= shunt_pkg::SLAVE_RESET;
		end
		else
		begin
			go <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= s_axi_awaddr;
				aw_have <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_have <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have && w_have && !s_axi_bvalid)
			begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= shunt_pkg::RESP_OKAY;
				unique case (aw_q)
					shunt_pkg::HOST_COMMAND:
						if (state == H_IDLE)
						begin
							go <= 1'b1;
							cmd_ptr <= w_q[7:0];
							rd_mode <= w_q[shunt_pkg::CMD_READ_BIT];
							last_byte <= w_q[shunt_pkg::CMD_READ_BIT] ? 2'h2 :
								(w_q[shunt_pkg::CMD_PTR_ONLY_BIT] ? 2'h1 : 2'h3);
						end
					shunt_pkg::HOST_WDATA:
					begin
						if (ws_q[0])
							wdata[7:0] <= w_q[7:0];
						if (ws_q[1])
							wdata[15:8] <= w_q[15:8];
					end
					shunt_pkg::HOST_SLAVE: slave <= w_q[6:0];
					shunt_pkg::HOST_STATUS, shunt_pkg::HOST_RDATA: ;
					default: s_axi_bresp <= shunt_pkg::RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= shunt_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= shunt_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				shunt_pkg::HOST_COMMAND: s_axi_rdata <= {22'h0, last_byte == 2'h1, rd_mode, cmd_ptr};
				shunt_pkg::HOST_WDATA: s_axi_rdata <= {16'h0000, wdata};
				shunt_pkg::HOST_STATUS: s_axi_rdata <= {29'h0, done, nack, state != H_IDLE};
				shunt_pkg::HOST_RDATA: s_axi_rdata <= {16'h0000, rx_word};
				shunt_pkg::HOST_SLAVE: s_axi_rdata <= {25'h0, slave};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= shunt_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Bus master sequencer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			qcnt <= '0;
		else if (state == H_IDLE || tick)
			qcnt <= '0;
		else
			qcnt <= qcnt + 1'b1;
	end

	// Only this end drives the clock and frames every transfer; a slave may stretch the clock low.
	// master drives clock
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= H_IDLE;
			phase <= 2'h0;
			bit_idx <= 4'h0;
			byte_idx <= 2'h0;
			rx_word <= 16'h0000;
			nack <= 1'b0;
			done <= 1'b0;
			link.host_scl_oe_n <= 1'b1;
			link.host_sda_oe_n <= 1'b1;
		end
		else if (state == H_IDLE)
		begin
			if (go)
			begin
				state <= H_START;
				phase <= 2'h0;
				bit_idx <= 4'h0;
				byte_idx <= 2'h0;
				nack <= 1'b0;
				done <= 1'b0;
			end
		end
		else if (tick && !(phase == 2'h2 && !link.scl))
		begin
			phase <= phase + 1'b1;
			unique case (state)
				H_START:
					unique case (phase)
						2'h1: link.host_sda_oe_n <= 1'b0;
						2'h2: link.host_scl_oe_n <= 1'b0;
						2'h3: state <= H_BIT;
						default: ;
					endcase
				H_BIT:
					unique case (phase)
						2'h0:
							if (bit_idx == 4'h8)
								link.host_sda_oe_n <= ~rx_byte || byte_idx == last_byte;
							else
								link.host_sda_oe_n <= rx_byte || tx_byte[~bit_idx[2:0]];
						2'h1: link.host_scl_oe_n <= 1'b1;
						2'h2:
							if (bit_idx != 4'h8 && rx_byte)
								rx_word <= {rx_word[14:0], link.sda};
							else if (bit_idx == 4'h8 && !rx_byte && link.sda)
								nack <= 1'b1;
						default:
						begin
							link.host_scl_oe_n <= 1'b0;
							if (bit_idx != 4'h8)
								bit_idx <= bit_idx + 1'b1;
							else if (nack || byte_idx == last_byte)
								state <= H_STOP;
							else
							begin
								bit_idx <= 4'h0;
								byte_idx <= byte_idx + 1'b1;
							end
						end
					endcase
				default:
					unique case (phase)
						2'h0: link.host_sda_oe_n <= 1'b0;
						2'h1: link.host_scl_oe_n <= 1'b1;
						2'h2: link.host_sda_oe_n <= 1'b1;
						default:
						begin
							state <= H_IDLE;
							done <= 1'b1;
						end
					endcase
			endcase
		end
	end

endmodule : two_wire_host

// ==== verification/shunt_power_calc_engine_assertions.sv ====
// Concurrent checks on the two-wire link between the host end and the device end.
`timescale 1ns/1ps
module shunt_power_calc_engine_assertions #(
	parameter int TIMEOUT_CYCLES = shunt_pkg::TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n
);
	default clocking main_cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Counts clocks since the last clock-line change, so a stall can be timed without long repetitions.
	logic scl_q;
	int quiet;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			scl_q <= 1'b1;
		else
			scl_q <= scl;
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			quiet <= 0;
		else if (scl != scl_q)
			quiet <= 0;
		else
			quiet <= quiet + 1;
	end

	// ----------------------------------------
	// Framing sequences
	// ----------------------------------------
	sequence s_start;
		$fell(sda) && scl && $past(scl);
	endsequence
	sequence s_stop;
		$rose(sda) && scl && $past(scl);
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_reset_idle:
	assert property ($rose(rst_n) |-> dev_sda_oe_n && host_sda_oe_n && host_scl_oe_n)
		else $error("Link not released after reset");
	a_start_hold:
	assert property (s_start |=> scl [*2])
		else $error("Clock line fell too soon after start");
	a_start_released:
	assert property (s_start |-> dev_sda_oe_n [*2])
		else $error("Device drove data during start");
	a_stop_released:
	assert property (s_stop |-> dev_sda_oe_n ##1 dev_sda_oe_n)
		else $error("Device drove data around stop");
	a_dev_stable_high:
	assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("Device changed data while clock high");
	a_dev_change_low:
	assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("Device data change outside clock low");
	a_ack_hold:
	assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
		else $error("Device drive shorter than a bit");
	a_stall_release:
	assert property (quiet > TIMEOUT_CYCLES + 2 |-> dev_sda_oe_n)
		else $error("Device held data line after stall");
endmodule : shunt_power_calc_engine_assertions

// ==== verification/shunt_power_calc_engine_test.sv ====
// Self-checking bench for the shunt power engine and its two-wire host.
`timescale 1ns/1ps
module shunt_power_calc_engine_test;
	localparam int QUARTER = 6;
	localparam int TIMEOUT = 400;
	localparam logic [31:0] PTR_ONLY = 32'h1 << shunt_pkg::CMD_PTR_ONLY_BIT;
	localparam logic [31:0] RD = 32'h1 << shunt_pkg::CMD_READ_BIT;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] shunt_raw = 16'h0;
	logic [12:0] bus_raw = 13'h0;
	logic sample_valid = 1'b0;
	logic [1:0] addr_sel = 2'h0;
	logic [15:0] config_word, current_result, power_result;
	logic [31:0] seed = 32'h63;
	longint exp_cur = 0, exp_pw = 0;
	int n_errors = 0;
	int samples_checked = 0;

	always #4 clock = ~clock;

	two_wire_if link_bus ();
	two_wire_host #(.QUARTER_CYCLES(QUARTER)) u_two_wire_host (.clock(clock), .rst_n(rst_n), .link(link_bus),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	shunt_power_engine #(.TIMEOUT_CYCLES(TIMEOUT)) u_shunt_power_engine (.clock(clock), .rst_n(rst_n),
		.link(link_bus), .shunt_raw(shunt_raw), .bus_raw(bus_raw), .sample_valid(sample_valid),
		.addr_sel(addr_sel), .config_word(config_word), .current_result(current_result),
		.power_result(power_result));
	shunt_power_calc_engine_assertions #(.TIMEOUT_CYCLES(TIMEOUT)) u_checker (.clock(clock), .rst_n(rst_n),
		.scl(link_bus.scl), .sda(link_bus.sda), .host_scl_oe_n(link_bus.host_scl_oe_n),
		.host_sda_oe_n(link_bus.host_sda_oe_n), .dev_sda_oe_n(link_bus.dev_sda_oe_n));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic conclude();
		$display("Mismatches %0d, comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic stall();
		n_errors++;
		$display("Error at %0t: wait ran out", $time);
		conclude();
	endtask : stall

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : compare

	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xorshift

	// ----------------------------------------
	// Register bus cycles
	// ----------------------------------------
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			n++;
			if (n > 50)
				stall();
		end
	endtask : axi_write

	task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			n++;
			if (n > 50)
				stall();
		end
	endtask : axi_read

	// ----------------------------------------
	// Link transactions through the host
	// ----------------------------------------
	task automatic link_cmd(input logic [31:0] cmd, input logic nack_exp);
		logic [31:0] s;
		logic [1:0] r;
		int n;
		n = 0;
		axi_write(shunt_pkg::HOST_COMMAND, cmd, r);
		do
		begin
			axi_read(shunt_pkg::HOST_STATUS, s, r);
			n++;
			if (n > 1000)
				stall();
		end
		while (s[0] !== 1'b0 || s[2] !== 1'b1);
		compare({31'h0, s[1]}, {31'h0, nack_exp});
	endtask : link_cmd

	task automatic link_write(input logic [7:0] ptr, input logic [15:0] d);
		logic [1:0] r;
		axi_write(shunt_pkg::HOST_WDATA, {16'h0, d}, r);
		link_cmd({24'h0, ptr}, 1'b0);
	endtask : link_write

	task automatic link_read(input logic [7:0] ptr, output logic [31:0] d);
		logic [1:0] r;
		link_cmd(PTR_ONLY | {24'h0, ptr}, 1'b0);
		link_cmd(RD | {24'h0, ptr}, 1'b0);
		axi_read(shunt_pkg::HOST_RDATA, d, r);
	endtask : link_read

	// ----------------------------------------
	// Arithmetic model and comparisons
	// ----------------------------------------
	// The model keeps its last results while calibration is zero, as the engine must.
	task automatic take_sample(input logic [15:0] cal);
		logic [31:0] v;
		v = xorshift();
		@(posedge clock);
		shunt_raw <= v[15:0];
		bus_raw <= v[28:16];
		sample_valid <= 1'b1;
		@(posedge clock);
		sample_valid <= 1'b0;
		repeat (4) @(posedge clock);
		if (cal != 16'h0)
		begin
			exp_cur = longint'($signed(v[15:0])) * longint'(cal) / shunt_pkg::CURRENT_DIVISOR;
			exp_cur = longint'($signed(exp_cur[15:0]));
			exp_pw = exp_cur * longint'(v[28:16]) / shunt_pkg::POWER_DIVISOR;
		end
		compare({16'h0, current_result}, {16'h0, exp_cur[15:0]});
		compare({16'h0, power_result}, {16'h0, exp_pw[15:0]});
	endtask : take_sample

	task automatic check_regs();
		logic [31:0] d;
		link_read(shunt_pkg::PTR_CURRENT, d);
		compare(d, {16'h0, exp_cur[15:0]});
		link_read(shunt_pkg::PTR_POWER, d);
		compare(d, {16'h0, exp_pw[15:0]});
		link_read(shunt_pkg::PTR_BUS, d);
		compare(d, {16'h0, bus_raw, 3'b000});
		link_read(shunt_pkg::PTR_SHUNT, d);
		compare(d, {16'h0, shunt_raw});
	endtask : check_regs

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] cal;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		compare({16'h0, config_word}, {16'h0, shunt_pkg::CONFIG_RESET});
		compare({current_result, power_result}, 32'h0);
		axi_read(shunt_pkg::HOST_SLAVE, d, r);
		compare(d, {25'h0, shunt_pkg::SLAVE_RESET});
		axi_read(5'h14, d, r);
		compare({d[29:0], r}, {30'h0, shunt_pkg::RESP_SLVERR});
		axi_write(5'h18, 32'h5, r);
		compare({30'h0, r}, {30'h0, shunt_pkg::RESP_SLVERR});
		take_sample(16'h0);
		check_regs();
		link_read(shunt_pkg::PTR_CONFIG, d);
		compare(d, {16'h0, shunt_pkg::CONFIG_RESET});
		// calibration from current step and shunt
		d = xorshift();
		cal = 16'(40960000 / ((50 + int'(d[7:0])) * (26 + int'(d[15:8]))));
		link_write(shunt_pkg::PTR_CAL, cal);
		link_read(shunt_pkg::PTR_CAL, d);
		compare(d, {16'h0, cal});
		repeat (4)
		begin
			take_sample(cal);
			check_regs();
		end
		link_write(shunt_pkg::PTR_CAL, 16'h0);
		take_sample(16'h0);
		axi_write(shunt_pkg::HOST_SLAVE, 32'h41, r);
		link_cmd(PTR_ONLY, 1'b1);
		addr_sel <= 2'h1;
		link_read(shunt_pkg::PTR_CONFIG, d);
		compare(d, {16'h0, shunt_pkg::CONFIG_RESET});
		d = xorshift();
		link_write(shunt_pkg::PTR_CONFIG, d[15:0]);
		compare({16'h0, config_word}, {16'h0, d[15:0]});
		rst_n <= 1'b0;
		addr_sel <= 2'h0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		exp_cur = 0;
		exp_pw = 0;
		compare({16'h0, config_word}, {16'h0, shunt_pkg::CONFIG_RESET});
		compare({current_result, power_result}, 32'h0);
		link_read(shunt_pkg::PTR_CAL, d);
		compare(d, 32'h0);
		take_sample(16'h0);
		repeat (TIMEOUT + 100) @(posedge clock);
		conclude();
	end
endmodule : shunt_power_calc_engine_test
